// ==== rtl/wake_input_controller.sv ====
// Wake input controller: filters, status, bias, sync reuse and fail-safe output
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps

module wake_input_controller
    import wake_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Register port
    input  wire logic [7:0]           addr,
    input  wire logic [7:0]           wdata,
    input  wire logic                 wr_en,
    input  wire logic                 rd_en,
    output logic      [7:0]           rdata,
    // Wake pins
    input  wire logic [3:0]           wake_input,
    output logic      [3:0]           pull_up_en,
    output logic      [3:0]           pull_down_en,
    output logic                      fail_safe_output,
    output logic                      hs_sync,
    // Device side
    input  wake_pkg::mode_t           dev_mode,
    input  wire logic                 soft_reset,
    input  wire logic [3:0]           high_side_output,
    input  wire logic                 sleep_request,
    input  wire logic                 other_wake_source,
    input  wake_pkg::fail_cond_t      fail_cond,
    output logic                      wake_irq,
    output logic                      wake_up_req,
    output logic                      sleep_grant,
    output logic                      restart_req,
    output logic                      fault_flag
);
    import wake_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration, status and fault state
    wake_bank_t cfg_reg [4];
    logic       fo_sel_reg;
    logic       lock_reg;
    logic [3:0] evt_reg;
    logic [3:0] level_reg;
    logic       fault_reg;
    logic       spi_err_reg;
    mode_t      prev_mode_reg;
    logic [2:0] wd_cnt_reg;
    logic [2:0] uv_cnt_reg;
    logic       wd_fault_reg;
    logic       uv_fault_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    logic [3:0] wr_bank;
    logic [3:0] wake_on;
    logic [3:0] bias_off;
    logic [3:0] level_now;
    logic [3:0] sampled;
    logic [3:0] cyc_mode;
    logic [3:0] sync_filt;
    logic [3:0] raw_edge;
    logic [3:0] init_kick;
    logic [3:0] evt_set;
    logic [3:0] evt_clr;
    logic [3:0] level_mask;
    logic [3:0] level_src;
    logic [3:0] pu_next;
    logic [3:0] pd_next;
    logic [7:0] bank_rd [4];

    wire sync_sel   = (cfg_reg[BANK_FOUR].en == EN_SYNC);
    wire fo_mode    = ~fo_sel_reg;
    wire mode_live  = (dev_mode == MODE_NORMAL) || (dev_mode == MODE_STOP)
                      || (dev_mode == MODE_INIT);
    wire irq_mode   = (dev_mode == MODE_NORMAL) || (dev_mode == MODE_STOP);
    wire wake_mode  = (dev_mode == MODE_SLEEP) || (dev_mode == MODE_FAILSAFE);
    wire init_exit  = (dev_mode == MODE_NORMAL) && (prev_mode_reg == MODE_INIT);
    wire wr_event   = wr_en && (addr == ADDR_EVENT);
    wire wr_dev     = wr_en && (addr == ADDR_DEV);
    wire lock_clash = wr_bank[BANK_TWO] && lock_reg && (wdata[FO_SEL_BIT] != fo_sel_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Per-input front end
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_in
            logic             s1_reg;
            logic             s2_reg;
            logic             acc_reg;
            logic             samp_reg;
            logic             hs_prev_reg;
            logic [CNT_W-1:0] cnt_reg;

            // Sample at the end of the on-time, when the sensor supply has settled
            wire              cyclic     = (cfg_reg[k].filt != FILT_16)
                                           && (cfg_reg[k].filt != FILT_64);
            wire [CNT_W-1:0]  limit      = (cfg_reg[k].filt == FILT_64) ?
                                           FILT_LONG_CNT : FILT_SHORT_CNT;
            wire              sample_now = hs_prev_reg & ~high_side_output[k];
            wire              static_hit = !cyclic && (s2_reg != acc_reg)
                                           && (cnt_reg == limit - 11'h001);
            wire              cyc_hit    = cyclic && sample_now
                                           && (s2_reg != samp_reg);

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_reg      <= 1'b0;
                    s2_reg      <= 1'b0;
                    acc_reg     <= 1'b0;
                    samp_reg    <= 1'b0;
                    hs_prev_reg <= 1'b0;
                    cnt_reg     <= '0;
                end else begin
                    s1_reg      <= wake_input[k];
                    s2_reg      <= s1_reg;
                    hs_prev_reg <= high_side_output[k];
                    if (cyclic) begin
                        acc_reg <= s2_reg;
                        cnt_reg <= '0;
                    end else if (s2_reg == acc_reg) begin
                        cnt_reg <= '0;
                    end else if (static_hit) begin
                        acc_reg <= s2_reg;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 11'h001;
                    end
                    if (sample_now) begin
                        samp_reg <= s2_reg;
                    end
                end
            end

            assign raw_edge[k]  = static_hit | cyc_hit;
            assign level_now[k] = s2_reg;
            assign sampled[k]   = samp_reg;
            assign cyc_mode[k]  = cyclic;
            assign sync_filt[k] = (cfg_reg[k].filt == FILT_SYNC);
            assign wr_bank[k]   = wr_en && (addr == ADDR_BANK[k]);

            // Pins in use as sync input or fail output carry no bias or wake
            if (k == BANK_FOUR) begin : g_four
                assign bias_off[k] = sync_sel;
                assign wake_on[k]  = (cfg_reg[k].en == EN_ON);
            end else if (k == BANK_TWO) begin : g_two
                assign bias_off[k] = fo_mode;
                assign wake_on[k]  = (cfg_reg[k].en == EN_ON) && fo_sel_reg;
            end else begin : g_plain
                assign bias_off[k] = 1'b0;
                assign wake_on[k]  = (cfg_reg[k].en == EN_ON);
            end

            assign pu_next[k] = !bias_off[k] && ((cfg_reg[k].bias == BIAS_UP)
                                || ((cfg_reg[k].bias == BIAS_AUTO) && s2_reg));
            assign pd_next[k] = !bias_off[k] && ((cfg_reg[k].bias == BIAS_DOWN)
                                || ((cfg_reg[k].bias == BIAS_AUTO) && !s2_reg));
            assign bank_rd[k] = {(k == BANK_TWO) ? fo_sel_reg : 1'b0, cfg_reg[k][6:0]};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Event and level status
    // Init only tracks levels; the Init-to-Normal kick catches non-cyclic inputs already active
    assign init_kick  = init_exit ? (wake_on & ~cyc_mode & level_now) : 4'h0;
    assign evt_set    = (raw_edge & wake_on & {4{dev_mode != MODE_INIT}})
                        | init_kick;
    assign evt_clr    = wr_event ? wdata[3:0] : 4'h0;
    assign level_mask = {sync_sel, 1'b0, fo_mode, 1'b0};
    assign level_src  = (cyc_mode & sampled) | (~cyc_mode & level_now);

    ////////////////////////////////////////////////////////////////////////////
    // Failure logic
    wire wd_hit    = fail_cond.wd_check && fail_cond.wd_fail
                     && (wd_cnt_reg == FAIL_COUNT_MAX - 3'h1);
    wire uv_hit    = fail_cond.uv_check && fail_cond.uv
                     && (uv_cnt_reg == FAIL_COUNT_MAX - 3'h1);
    wire cond_now  = wd_fault_reg || uv_fault_reg || fail_cond.tsd || fail_cond.vreg_short
                     || (fail_cond.vreg_ov && (fail_cond.ov_mode == OV_MODE_FAIL));
    // Flag holds while any cause remains, so a clear cannot beat a live failure
    wire fault_next = cond_now || (fault_reg && !(wr_dev && wdata[FAULT_BIT]));
    wire only_sync = (|wake_on) && ((wake_on & sync_filt) == wake_on)
                     && !other_wake_source;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    wire [7:0] rd_mux = (addr == ADDR_EVENT) ? {4'h0, evt_reg} :
                        (addr == ADDR_LEVEL) ? {4'h0, level_reg} :
                        (addr == ADDR_DEV)   ? {6'h00, spi_err_reg, fault_reg} :
                        wr_bank_hit(0)       ? bank_rd[0] :
                        wr_bank_hit(1)       ? bank_rd[1] :
                        wr_bank_hit(2)       ? bank_rd[2] :
                        wr_bank_hit(3)       ? bank_rd[3] : 8'h00;

    function automatic logic wr_bank_hit(input int idx);
        wr_bank_hit = (addr == ADDR_BANK[idx]);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                cfg_reg[i] <= BANK_RESET;
            end
            fo_sel_reg  <= FO_SEL_RESET;
            lock_reg    <= 1'b0;
            evt_reg     <= 4'h0;
            spi_err_reg <= 1'b0;
        end else if (soft_reset) begin
            for (int i = 0; i < 4; i++) begin
                cfg_reg[i] <= BANK_RESET;
            end
            fo_sel_reg  <= FO_SEL_RESET;
            lock_reg    <= 1'b0;
            evt_reg     <= 4'h0;
            spi_err_reg <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_bank[i]) begin
                    cfg_reg[i] <= {1'b0, wdata[6:0]};
                end
            end
            if (wr_bank[BANK_TWO] && !lock_reg) begin
                fo_sel_reg <= wdata[FO_SEL_BIT];
                lock_reg   <= 1'b1;
            end
            evt_reg     <= (evt_reg & ~evt_clr) | evt_set;
            spi_err_reg <= lock_clash || (spi_err_reg && !(wr_dev && wdata[SPIERR_BIT]));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_cnt_reg   <= 3'h0;
            uv_cnt_reg   <= 3'h0;
            wd_fault_reg <= 1'b0;
            uv_fault_reg <= 1'b0;
            fault_reg    <= 1'b0;
        end else begin
            if (fail_cond.wd_check) begin
                wd_cnt_reg   <= (!fail_cond.wd_fail || wd_hit) ? 3'h0 : wd_cnt_reg + 3'h1;
                wd_fault_reg <= wd_hit || (wd_fault_reg && fail_cond.wd_fail);
            end
            if (fail_cond.uv_check) begin
                uv_cnt_reg   <= (!fail_cond.uv || uv_hit) ? 3'h0 : uv_cnt_reg + 3'h1;
                uv_fault_reg <= uv_hit || (uv_fault_reg && fail_cond.uv);
            end
            fault_reg <= fault_next;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_mode_reg    <= MODE_INIT;
            level_reg        <= 4'h0;
            pull_up_en       <= 4'h0;
            pull_down_en     <= 4'h0;
            fail_safe_output <= 1'b0;
            hs_sync          <= 1'b0;
            wake_irq         <= 1'b0;
            wake_up_req      <= 1'b0;
            sleep_grant      <= 1'b0;
            restart_req      <= 1'b0;
            rdata            <= 8'h00;
        end else begin
            prev_mode_reg    <= dev_mode;
            if (mode_live) begin
                level_reg <= level_src & ~level_mask;
            end
            pull_up_en       <= pu_next;
            pull_down_en     <= pd_next;
            fail_safe_output <= fault_next && fo_mode;
            hs_sync          <= sync_sel && level_now[BANK_FOUR];
            wake_irq         <= (|evt_set) && irq_mode;
            wake_up_req      <= (|evt_set) && wake_mode;
            sleep_grant      <= sleep_request && !only_sync;
            restart_req      <= sleep_request && only_sync;
            rdata            <= rd_en ? rd_mux : 8'h00;
        end
    end

    assign fault_flag = fault_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_bias_default: assert property (@(posedge clk) disable iff (rst)
        (cfg_reg[0].bias == BIAS_NONE) |=> (!pull_up_en[0] && !pull_down_en[0]))
        else $error("bias none drives a current source");
    a_bias_auto: assert property (@(posedge clk) disable iff (rst)
        (cfg_reg[0].bias == BIAS_AUTO) |=>
        (pull_up_en[0] == $past(level_now[0])) && (pull_down_en[0] != $past(level_now[0])))
        else $error("automatic bias does not follow input");
    a_event_record: assert property (@(posedge clk) disable iff (rst || soft_reset)
        evt_set[0] |=> evt_reg[0])
        else $error("wake event not recorded");
    a_event_sticky: assert property (@(posedge clk) disable iff (rst)
        (evt_reg[0] && !soft_reset && !(wr_event && wdata[0])) |=> evt_reg[0])
        else $error("event status lost without clear");
    a_disabled_quiet: assert property (@(posedge clk) disable iff (rst)
        !wake_on[1] |-> !evt_set[1])
        else $error("disabled input raised an event");
    a_sync_ignored: assert property (@(posedge clk) disable iff (rst)
        sync_sel |-> !evt_set[3] ##1 (!pull_up_en[3] && !pull_down_en[3]))
        else $error("sync input kept wake or bias");
    a_level_hidden: assert property (@(posedge clk) disable iff (rst)
        (sync_sel && $past(sync_sel) && fo_mode && $past(fo_mode)) |-> (!level_reg[3] && !level_reg[1]))
        else $error("hidden level reported");
    a_lock_error: assert property (@(posedge clk) disable iff (rst)
        (lock_clash && !soft_reset) |=> (spi_err_reg && $stable(fo_sel_reg)))
        else $error("locked select changed or no error");
    a_fail_on: assert property (@(posedge clk) disable iff (rst)
        (cond_now && fo_mode) |=> (fail_safe_output && fault_reg))
        else $error("failure did not drive fail output");
    a_sleep_refuse: assert property (@(posedge clk) disable iff (rst)
        (sleep_request && only_sync) |=> (restart_req && !sleep_grant))
        else $error("sleep not refused with only sync source");
    a_init_kick: assert property (@(posedge clk) disable iff (rst || soft_reset)
        (init_exit && wake_on[0] && !cyc_mode[0] && level_now[0]) |=> (evt_reg[0] && wake_irq))
        else $error("init exit did not flag active input");

endmodule

// ==== rtl/wake_pkg.sv ====
// Constants, codes and carriers for the wake input controller
package wake_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and filter timing
    localparam int          CLK_HZ         = 25_000_000;
    localparam int          CLK_MHZ        = CLK_HZ / 1_000_000;
    localparam int          FILT_SHORT_US  = 16;
    localparam int          FILT_LONG_US   = 64;
    localparam int          CNT_W          = 11;
    localparam logic [10:0] FILT_SHORT_CNT = 11'(FILT_SHORT_US * CLK_MHZ);
    localparam logic [10:0] FILT_LONG_CNT  = 11'(FILT_LONG_US * CLK_MHZ);
    localparam logic [2:0]  FAIL_COUNT_MAX = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [3:0][7:0] ADDR_BANK  = {8'h0c, 8'h08, 8'h04, 8'h00};
    localparam logic [7:0]      ADDR_EVENT = 8'h10;
    localparam logic [7:0]      ADDR_LEVEL = 8'h14;
    localparam logic [7:0]      ADDR_DEV   = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int          FO_SEL_BIT  = 7;
    localparam int          FAULT_BIT   = 0;
    localparam int          SPIERR_BIT  = 1;
    localparam int          BANK_TWO    = 1;
    localparam int          BANK_FOUR   = 3;
    localparam logic [7:0]  BANK_RESET  = 8'h00;
    localparam logic        FO_SEL_RESET = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Field codes
    localparam logic [1:0] EN_OFF    = 2'h0;
    localparam logic [1:0] EN_ON     = 2'h1;
    localparam logic [1:0] EN_SYNC   = 2'h2;
    localparam logic [1:0] BIAS_NONE = 2'h0;
    localparam logic [1:0] BIAS_DOWN = 2'h1;
    localparam logic [1:0] BIAS_UP   = 2'h2;
    localparam logic [1:0] BIAS_AUTO = 2'h3;
    localparam logic [2:0] FILT_16   = 3'h0;
    localparam logic [2:0] FILT_64   = 3'h1;
    localparam logic [2:0] FILT_SYNC = 3'h4;
    localparam logic [1:0] OV_MODE_FAIL = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [5:0] {
        MODE_INIT     = 6'h01,
        MODE_NORMAL   = 6'h02,
        MODE_STOP     = 6'h04,
        MODE_SLEEP    = 6'h08,
        MODE_FAILSAFE = 6'h10,
        MODE_RESTART  = 6'h20
    } mode_t;

    typedef struct packed {
        logic       fo_sel;
        logic [2:0] filt;
        logic [1:0] bias;
        logic [1:0] en;
    } wake_bank_t;

    typedef struct packed {
        logic       wd_check;
        logic       wd_fail;
        logic       tsd;
        logic       vreg_short;
        logic       vreg_ov;
        logic [1:0] ov_mode;
        logic       uv_check;
        logic       uv;
    } fail_cond_t;

endpackage

// ==== dv/wake_switches.sv ====
// Model of the switches and sensors on the wake pins
`timescale 1ns/10ps
module wake_switches (
    // Clock
    input  wire logic       clk,
    // Switch setting
    input  wire logic [3:0] level,
    input  wire logic [3:0] drive,
    // Current sources
    input  wire logic [3:0] pull_up_en,
    input  wire logic [3:0] pull_down_en,
    // Pins
    output logic      [3:0] pin
);
    logic wobble = 1'b0;
    // An open pin with no source has no defined level, so it wanders
    always @(posedge clk) begin
        wobble <= ~wobble;
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (drive[i]) begin
                pin[i] = level[i];
            end else if (pull_up_en[i]) begin
                pin[i] = 1'b1;
            end else if (pull_down_en[i]) begin
                pin[i] = 1'b0;
            end else begin
                pin[i] = wobble;
            end
        end
    end
endmodule

// ==== dv/wake_input_controller_bench.sv ====
// Self-checking bench for the wake input controller
`timescale 1ns/10ps
module wake_input_controller_bench;
    import wake_pkg::*;
    logic       clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [3:0] pin, pu, pd, lvl = 4'h0, hs_on = 4'h0, drv = 4'hf;
    logic       fo, sync, irq, wup, grant, restart, fault;
    logic       soft_reset = 1'b0, sleep_request = 1'b0, other_wake = 1'b0;
    mode_t      dev_mode = MODE_INIT;
    fail_cond_t fail_cond = '0;
    int         fails = 0, checked = 0, irqs = 0, wakes = 0;

    wake_switches wake_switches_i (.clk(clk), .level(lvl), .drive(drv),
        .pull_up_en(pu), .pull_down_en(pd), .pin(pin));
    wake_input_controller wake_input_controller_i (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .wake_input(pin),
        .pull_up_en(pu), .pull_down_en(pd), .fail_safe_output(fo), .hs_sync(sync),
        .dev_mode(dev_mode), .soft_reset(soft_reset), .high_side_output(hs_on),
        .sleep_request(sleep_request), .other_wake_source(other_wake),
        .fail_cond(fail_cond), .wake_irq(irq), .wake_up_req(wup),
        .sleep_grant(grant), .restart_req(restart), .fault_flag(fault));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (irq === 1'b1) irqs <= irqs + 1;
        if (wup === 1'b1) wakes <= wakes + 1;
    end
    task automatic end_of_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk(what, rdata, exp);
        @(posedge clk);
    endtask
    task automatic sleep(input logic [1:0] exp);
        @(posedge clk);
        sleep_request <= 1'b1;
        @(posedge clk);
        sleep_request <= 1'b0;
        @(negedge clk);
        chk("sleep answer", {6'h0, grant, restart}, {6'h0, exp});
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_of_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) rd(ADDR_BANK[i], BANK_RESET, "bank reset");
        rd(ADDR_DEV, 8'h00, "status reset");
        for (int c = 0; c < 8; c++) begin
            @(posedge clk);
            lvl[0] <= c[2];
            wr(ADDR_BANK[0], {4'h0, c[1:0], EN_OFF});
            repeat (6) @(negedge clk);
            chk("pull up", {7'h0, pu[0]}, {7'h0, c[1:0] == 2'h2 || c[2:0] == 3'h7});
            chk("pull down", {7'h0, pd[0]}, {7'h0, c[1:0] == 2'h1 || c[2:0] == 3'h3});
        end
        // Input one high at the move out of init
        wr(ADDR_BANK[0], {1'b0, FILT_16, BIAS_NONE, EN_ON});
        // Let the filter accept the high level while init masks events
        repeat (500) @(posedge clk);
        dev_mode <= MODE_NORMAL;
        repeat (6) @(posedge clk);
        rd(ADDR_EVENT, 8'h01, "init kick");
        chk("irq count", 8'(irqs), 8'h01);
        wr(ADDR_EVENT, 8'h0f);
        lvl[0] <= 1'b0;
        repeat (200) @(posedge clk);
        lvl[0] <= 1'b1;
        repeat (500) @(posedge clk);
        rd(ADDR_EVENT, 8'h00, "short pulse");
        // Input three and four are disabled, so only input one reports
        lvl <= 4'b1100;
        repeat (500) @(posedge clk);
        rd(ADDR_EVENT, 8'h01, "held edge");
        chk("irq count", 8'(irqs), 8'h02);
        rd(ADDR_EVENT, 8'h01, "sticky");
        wr(ADDR_EVENT, 8'h01);
        rd(ADDR_EVENT, 8'h00, "cleared");
        lvl <= 4'b1110;
        repeat (6) @(posedge clk);
        rd(ADDR_LEVEL, 8'h0c, "level");
        dev_mode <= MODE_SLEEP;
        lvl[0] <= 1'b1;
        repeat (500) @(negedge clk);
        chk("wake count", {wakes[3:0], irqs[3:0]}, 8'h12);
        @(posedge clk);
        dev_mode <= MODE_NORMAL;
        // Input four is switched off before it becomes the sync input
        wr(ADDR_BANK[3], 8'h00);
        wr(ADDR_BANK[3], 8'h3e);
        repeat (6) @(negedge clk);
        chk("sync high", {sync, 3'h0, pu[3], pd[3], 2'h0}, 8'h80);
        @(posedge clk);
        lvl[3] <= 1'b0;
        repeat (500) @(negedge clk);
        chk("sync low", {7'h0, sync}, 8'h00);
        rd(ADDR_LEVEL, 8'h05, "level hidden");
        rd(ADDR_EVENT, 8'h01, "no sync event");
        fail_cond.tsd <= 1'b1;
        repeat (3) @(negedge clk);
        chk("fault on", {6'h0, fault, fo}, 8'h03);
        wr(ADDR_DEV, 8'h01);
        rd(ADDR_DEV, 8'h01, "fault held");
        fail_cond.tsd <= 1'b0;
        wr(ADDR_DEV, 8'h01);
        rd(ADDR_DEV, 8'h00, "fault cleared");
        chk("fault off", {6'h0, fault, fo}, 8'h00);
        wr(ADDR_BANK[1], 8'h80);
        wr(ADDR_BANK[1], 8'h00);
        rd(ADDR_BANK[1], 8'h80, "locked");
        rd(ADDR_DEV, 8'h02, "access error");
        @(posedge clk);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        rd(ADDR_BANK[1], 8'h00, "unlocked");
        wr(ADDR_BANK[3], 8'h00);
        wr(ADDR_BANK[0], {1'b0, FILT_SYNC, BIAS_NONE, EN_ON});
        sleep(2'b01);
        other_wake <= 1'b1;
        sleep(2'b10);
        // Cyclic: a change counts only when sampled at the end of the on-time
        hs_on[0] <= 1'b1;
        repeat (4) @(posedge clk);
        hs_on[0] <= 1'b0;
        repeat (4) @(posedge clk);
        rd(ADDR_EVENT, 8'h01, "cyclic change");
        rd(ADDR_LEVEL, 8'h05, "cyclic level");
        wr(ADDR_EVENT, 8'h01);
        lvl[0] <= 1'b0;
        wr(ADDR_BANK[2], 8'h04);
        drv[2] <= 1'b0;
        repeat (6) @(posedge clk);
        rd(ADDR_LEVEL, 8'h01, "sampled level held");
        rd(ADDR_EVENT, 8'h00, "no sample no event");
        end_of_test;
    end
endmodule
